// ===== pkg/timer_pkg.sv
// constants, field layout and carrier types for the 16-bit timer
// Contract
// - The counter advances only while count_run_enable (bit 0) is set.
// - With count_source_select clear it counts once per instruction cycle.
// - With count_source_select set it counts rising edges of the pin or osc.
// - External inputs always pass the two-stage synchroniser; external_sync_bypass skips the extra edge stage and, in counter mode, blocks special events.
// - Bits 5-4 pick a prescale of 1, 2, 4 or 8 on the chosen source.
// - Bit 3 turns the low-power oscillator amplifier on, clear shuts it off.
// - Bit 6 reads 1 while the system clock comes from the low-power osc.
// - Bit 7 selects atomic 16-bit access instead of two byte accesses.
// - In wide mode a low-byte read copies the live high byte to a buffer.
// - In wide mode high writes fill the buffer and low writes load both.
// - Low-byte writes clear the prescaler; high-byte writes never do.
// - While enabled both pins are forced to inputs and port reads give 0.
// - The low-power oscillator keeps running in every power mode if enabled.
// - The counter wraps from ffff to 0000 and each wrap latches overflow unless a counter write lands in the same cycle.
// - A counter write beats a special-event reset, which never flags.
package timer_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_CTRL  = 8'h00;
  localparam logic [7:0] ADDR_LOW   = 8'h04;
  localparam logic [7:0] ADDR_HIGH  = 8'h08;
  localparam logic [7:0] ADDR_STAT  = 8'h0c;
  localparam logic [7:0] ADDR_MASK  = 8'h10;
  // field positions
  localparam int BIT_SYSCLK = 6;
  localparam int BIT_OVF    = 0;
  // reset values
  localparam logic [7:0]  CTRL_RESET  = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_TOP   = 16'hffff;
  // timing: clock is the oscillator, instruction cycle is a quarter of it
  localparam int CLK_MHZ      = 100;
  localparam int INSTR_DIV    = 4;
  localparam logic [1:0] QTR_LAST = 2'(INSTR_DIV - 1);

  // control register layout, msb first
  typedef struct packed {
    logic       wide_access_mode;
    logic       sysclk_from_lp_osc;
    logic [1:0] input_prescale_select;
    logic       low_power_osc_enable;
    logic       external_sync_bypass;
    logic       count_source_select;
    logic       count_run_enable;
  } timer_control_t;

  // pin group toward the port logic
  typedef struct packed {
    logic [1:0] out;
    logic [1:0] oe_n;
    logic [1:0] port_rd;
  } pin_group_t;
endpackage : timer_pkg

// ===== design/timer_counter.sv
// 16-bit timer/counter with prescaler, wide access and wishbone registers
//
// Added by the designer: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module timer_counter (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // pins: bit 0 count input, bit 1 osc input
  input  wire logic        external_count_input_i,
  input  wire logic        lp_osc_input_pin_i,
  input  wire logic        lp_osc_clk_i,
  input  wire logic [1:0]  port_c_direction_i,
  input  wire logic [1:0]  port_out_i,
  output timer_pkg::pin_group_t pins_o,
  // system side
  input  wire logic        sysclk_from_lp_osc_i,
  input  wire logic        special_event_i,
  output logic             lp_osc_amp_en_o,
  output logic             irq_o
);

  // state
  timer_pkg::timer_control_t ctrl_q, ctrl_d;
  logic [15:0] count_q, count_d;
  logic [7:0]  hbuf_q, hbuf_d;
  logic [2:0]  psc_q, psc_d;
  logic [1:0]  qtr_q, qtr_d;
  logic        stat_q, stat_d;
  logic        mask_q, mask_d;
  logic        ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  logic [2:0]  sync1_q, sync2_q;
  logic        prev_q, edge_s_q;
  logic        amp_q;
  timer_pkg::pin_group_t pins_q, pins_d;

  // decode
  logic        req, wr, rd, wr_low, wr_high, rd_low, rd_stat;
  logic        qtr_tick, src_sel, edge_u, ext_edge, src_tick;
  logic        psc_tick, inc, sev_hit, cnt_wr, wrap;
  logic [2:0]  psc_last;

  // bus request decode, one access per ack
  always_comb begin
    req     = cyc_i && stb_i && !ack_q;
    wr      = req && we_i && sel_i[0];
    rd      = req && !we_i;
    wr_low  = wr && (adr_i == timer_pkg::ADDR_LOW);
    wr_high = wr && (adr_i == timer_pkg::ADDR_HIGH);
    rd_low  = rd && (adr_i == timer_pkg::ADDR_LOW);
    rd_stat = rd && (adr_i == timer_pkg::ADDR_STAT);
    cnt_wr  = wr_low || (wr_high && !ctrl_q.wide_access_mode);
  end

  // count source selection and prescaler tick
  always_comb begin
    qtr_tick = (qtr_q == timer_pkg::QTR_LAST);
    // oscillator output replaces the count pin when on
    src_sel  = ctrl_q.low_power_osc_enable ? sync2_q[2] : sync2_q[0];
    edge_u   = src_sel && !prev_q;
    // extra stage delays the edge by one clock
    ext_edge = ctrl_q.external_sync_bypass ? edge_u : edge_s_q;
    src_tick = ctrl_q.count_source_select ? ext_edge : qtr_tick;
    psc_last = 3'((4'h1 << ctrl_q.input_prescale_select) - 4'h1);
    psc_tick = src_tick && (psc_q == psc_last);
    inc      = ctrl_q.count_run_enable && psc_tick;
    wrap     = inc && (count_q == timer_pkg::COUNT_TOP);
    // special event only valid in timer or synchronous counter mode
    sev_hit  = special_event_i &&
               !(ctrl_q.count_source_select &&
                 ctrl_q.external_sync_bypass);
  end

  // next state of the counting logic
  always_comb begin
    qtr_d   = qtr_tick ? 2'h0 : 2'(qtr_q + 2'h1);
    psc_d   = psc_q;
    count_d = count_q;
    hbuf_d  = hbuf_q;
    if (ctrl_q.count_run_enable && src_tick) begin
      psc_d = psc_tick ? 3'h0 : 3'(psc_q + 3'h1);
    end
    if (wr_low) begin
      psc_d = 3'h0;
    end
    if (inc) begin
      count_d = 16'(count_q + 16'h0001);
    end
    if (sev_hit) begin
      count_d = timer_pkg::COUNT_RESET;
    end
    // software write wins over increment and special event
    if (wr_low && ctrl_q.wide_access_mode) begin
      count_d = {hbuf_q, dat_i[7:0]};
    end else if (wr_low) begin
      count_d[7:0] = dat_i[7:0];
    end
    if (wr_high && ctrl_q.wide_access_mode) begin
      hbuf_d = dat_i[7:0];
    end else if (wr_high) begin
      count_d[15:8] = dat_i[7:0];
    end
    if (rd_low && ctrl_q.wide_access_mode) begin
      hbuf_d = count_q[15:8];
    end
  end

  // next state of registers, flags and read data
  always_comb begin
    ctrl_d = ctrl_q;
    mask_d = mask_q;
    stat_d = stat_q;
    ack_d  = req;
    rdat_d = 32'h0000_0000;
    if (wr && (adr_i == timer_pkg::ADDR_CTRL)) begin
      ctrl_d = dat_i[7:0];
      ctrl_d.sysclk_from_lp_osc = 1'b0; // read-only bit
    end
    if (wr && (adr_i == timer_pkg::ADDR_MASK)) begin
      mask_d = dat_i[timer_pkg::BIT_OVF];
    end
    if (rd_stat) begin
      stat_d = 1'b0;
    end
    if (wrap && !cnt_wr) begin
      stat_d = 1'b1; // set beats read clear
    end
    if (rd) begin
      if (adr_i == timer_pkg::ADDR_CTRL) begin
        rdat_d[7:0] = ctrl_q;
        rdat_d[timer_pkg::BIT_SYSCLK] = sysclk_from_lp_osc_i;
      end else if (adr_i == timer_pkg::ADDR_LOW) begin
        rdat_d[7:0] = count_q[7:0];
      end else if (adr_i == timer_pkg::ADDR_HIGH) begin
        rdat_d[7:0] = ctrl_q.wide_access_mode ? hbuf_q : count_q[15:8];
      end else if (adr_i == timer_pkg::ADDR_STAT) begin
        rdat_d[timer_pkg::BIT_OVF] = stat_q;
      end else if (adr_i == timer_pkg::ADDR_MASK) begin
        rdat_d[timer_pkg::BIT_OVF] = mask_q;
      end
    end
  end

  // pin control: enabled block takes both pins as inputs
  always_comb begin
    pins_d.out = port_out_i;
    if (ctrl_q.count_run_enable) begin
      pins_d.oe_n    = 2'b11;
      pins_d.port_rd = 2'b00;
    end else begin
      pins_d.oe_n    = port_c_direction_i;
      pins_d.port_rd = sync2_q[1:0];
    end
  end

  // synchroniser, second stage feeds all logic
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_q  <= 3'h0;
      sync2_q  <= 3'h0;
      prev_q   <= 1'b0;
      edge_s_q <= 1'b0;
    end else begin
      sync1_q  <= {lp_osc_clk_i, lp_osc_input_pin_i,
                   external_count_input_i};
      sync2_q  <= sync1_q;
      prev_q   <= src_sel;
      edge_s_q <= edge_u;
    end
  end

  // register all state except the synchroniser and edge stages
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q  <= timer_pkg::CTRL_RESET;
      count_q <= timer_pkg::COUNT_RESET;
      hbuf_q  <= 8'h00;
      psc_q   <= 3'h0;
      qtr_q   <= 2'h0;
      stat_q  <= 1'b0;
      mask_q  <= 1'b0;
      ack_q   <= 1'b0;
      rdat_q  <= 32'h0000_0000;
      amp_q   <= 1'b0;
      pins_q  <= '{out: 2'b00, oe_n: 2'b11, port_rd: 2'b00};
    end else begin
      ctrl_q  <= ctrl_d;
      count_q <= count_d;
      hbuf_q  <= hbuf_d;
      psc_q   <= psc_d;
      qtr_q   <= qtr_d;
      stat_q  <= stat_d;
      mask_q  <= mask_d;
      ack_q   <= ack_d;
      rdat_q  <= rdat_d;
      // amplifier follows the enable only, no power-mode gating
      amp_q   <= ctrl_d.low_power_osc_enable;
      pins_q  <= pins_d;
    end
  end

  // outputs
  assign dat_o           = rdat_q;
  assign ack_o           = ack_q;
  assign pins_o          = pins_q;
  assign lp_osc_amp_en_o = amp_q;
  assign irq_o           = stat_q && mask_q;

  // checks
  sequence s_low_write_wide;
    wr_low && ctrl_q.wide_access_mode;
  endsequence

  sequence s_low_read_wide;
    rd_low && ctrl_q.wide_access_mode;
  endsequence

  a_hold_when_off: assert property (@(posedge clk_i)
    disable iff (rst_i)
    (!ctrl_q.count_run_enable && !cnt_wr && !sev_hit)
      |=> count_q == $past(count_q))
    else $error("count moved while stopped");

  a_instr_rate: assert property (@(posedge clk_i)
    disable iff (rst_i)
    (inc && !ctrl_q.count_source_select) |-> qtr_q == 2'h3)
    else $error("internal count off the instruction phase");

  a_ext_only_edge: assert property (@(posedge clk_i)
    disable iff (rst_i)
    (inc && ctrl_q.count_source_select) |-> ext_edge)
    else $error("external count without an edge");

  a_sync_delay: assert property (@(posedge clk_i)
    disable iff (rst_i)
    (ctrl_q.count_source_select && !ctrl_q.external_sync_bypass &&
     src_tick) |-> $past(edge_u))
    else $error("synchronised edge not delayed");

  a_prescale_eight: assert property (@(posedge clk_i)
    disable iff (rst_i)
    (inc && ctrl_q.input_prescale_select == 2'b11) |-> psc_q == 3'h7)
    else $error("prescale 1:8 wrong");

  a_wide_read_buf: assert property (@(posedge clk_i)
    disable iff (rst_i)
    s_low_read_wide |=> hbuf_q == $past(count_q[15:8]))
    else $error("high buffer not captured on low read");

  a_wide_write_load: assert property (@(posedge clk_i)
    disable iff (rst_i)
    s_low_write_wide |=> count_q == {$past(hbuf_q), $past(dat_i[7:0])})
    else $error("wide write did not load both bytes");

  a_psc_cleared: assert property (@(posedge clk_i)
    disable iff (rst_i)
    wr_low |=> psc_q == 3'h0)
    else $error("prescaler not cleared by low write");

  a_pins_input: assert property (@(posedge clk_i)
    disable iff (rst_i)
    ctrl_q.count_run_enable |=> pins_o.oe_n == 2'b11 &&
      pins_o.port_rd == 2'b00)
    else $error("pins not forced to input");

  a_wrap_flag: assert property (@(posedge clk_i)
    disable iff (rst_i)
    (wrap && !cnt_wr && !sev_hit) |=> count_q == 16'h0000 && stat_q
      ##1 (stat_q || $past(rd_stat)))
    else $error("wrap did not latch overflow");

  a_write_wins: assert property (@(posedge clk_i)
    disable iff (rst_i)
    (wr_low && sev_hit && !ctrl_q.wide_access_mode)
      |=> count_q[7:0] == $past(dat_i[7:0]))
    else $error("special event beat the write");

  a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    req |=> ack_o ##1 !ack_o)
    else $error("ack not a single cycle");

endmodule // timer_counter
`default_nettype wire

// ===== tb/timer_counter_tb.sv
// self-checking bench for the 16-bit timer/counter
`timescale 1ns/1ps
`default_nettype none
module timer_counter_tb;
  localparam logic [7:0] C = timer_pkg::ADDR_CTRL;
  localparam logic [7:0] L = timer_pkg::ADDR_LOW;
  localparam logic [7:0] H = timer_pkg::ADDR_HIGH;
  localparam logic [7:0] S = timer_pkg::ADDR_STAT;
  localparam logic [7:0] M = timer_pkg::ADDR_MASK;
  logic                  clk_i, rst_i, cyc, stb, we, ack;
  logic                  ext, oin, oclk, sys, sev, amp, irq;
  logic [7:0]            adr, q;
  logic [3:0]            sel;
  logic [31:0]           dat, rdat;
  logic [1:0]            dir, pout;
  timer_pkg::pin_group_t pins;
  int                    n_mismatch, n_tests;

  timer_counter dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(rdat),
    .ack_o(ack), .external_count_input_i(ext), .lp_osc_input_pin_i(oin),
    .lp_osc_clk_i(oclk), .port_c_direction_i(dir), .port_out_i(pout),
    .pins_o(pins), .sysclk_from_lp_osc_i(sys), .special_event_i(sev),
    .lp_osc_amp_en_o(amp), .irq_o(irq));

  task automatic finish_test();
    if (n_mismatch == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // one classic bus cycle, held until ack is sampled
  task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d);
    int n;
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= {24'h000000, d};
    for (n = 0; n < 20; n++) begin
      @(posedge clk_i);
      if (ack === 1'b1) break;
    end
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    if (n == 20) begin
      n_mismatch++;
      finish_test();
    end
    @(posedge clk_i);
  endtask

  task automatic t_reset();
    for (int i = 0; i < 3; i++) begin
      wb(8'(4 * i), 1'b0, 8'h00);
      chk("reset value", q, 8'h00);
    end
    wb(8'h14, 1'b0, 8'h00);
    chk("unmapped read", q, 8'h00);
  endtask

  task automatic t_prescale();
    logic [7:0] e;
    for (int ps = 0; ps < 4; ps++) begin
      wb(C, 1'b1, 8'h00);
      wb(H, 1'b1, 8'h00);
      wb(L, 1'b1, 8'h00);
      wb(C, 1'b1, {2'b00, 2'(ps), 4'h1});
      tick(400);
      wb(C, 1'b1, {2'b00, 2'(ps), 4'h0});
      wb(L, 1'b0, 8'h00);
      e = 8'(100 >> ps);
      chk("count", 8'(q >= e-1 && q <= e+1), 8'h01);
    end
    e = q;
    tick(40);
    wb(L, 1'b0, 8'h00);
    chk("held count", q, e);
  endtask

  task automatic t_wide();
    wb(H, 1'b1, 8'h12);
    wb(L, 1'b1, 8'hff);
    wb(C, 1'b1, 8'h80);
    wb(H, 1'b1, 8'h56);
    wb(C, 1'b1, 8'h00);
    wb(H, 1'b0, 8'h00);
    chk("live high", q, 8'h12);
    wb(C, 1'b1, 8'h80);
    wb(H, 1'b1, 8'h56);
    wb(L, 1'b1, 8'h78);
    wb(H, 1'b1, 8'h9a);
    wb(L, 1'b0, 8'h00);
    chk("wide low", q, 8'h78);
    wb(H, 1'b0, 8'h00);
    chk("captured high", q, 8'h56);
    wb(C, 1'b1, 8'h00);
  endtask

  task automatic t_ovf(input logic m);
    wb(M, 1'b1, {7'h00, m});
    wb(H, 1'b1, 8'hff);
    wb(L, 1'b1, 8'hfc);
    wb(C, 1'b1, 8'h01);
    for (int n = 0; n < 40 && irq !== 1'b1; n++) @(negedge clk_i);
    @(posedge clk_i);
    chk("irq", {7'h00, irq}, {7'h00, m});
    wb(C, 1'b1, 8'h00);
    wb(H, 1'b0, 8'h00);
    chk("wrapped high", q, 8'h00);
    wb(S, 1'b0, 8'h00);
    chk("overflow", q, 8'h01);
    wb(S, 1'b0, 8'h00);
    chk("overflow cleared", q, 8'h00);
    chk("irq cleared", {7'h00, irq}, 8'h00);
  endtask

  task automatic t_ext(input logic [7:0] c, input logic use_osc);
    wb(C, 1'b1, c & 8'hfe);
    // oscillator start-up delay before it is relied on
    if (use_osc) tick(20);
    wb(L, 1'b1, 8'h00);
    wb(C, 1'b1, c);
    repeat (5) begin
      if (use_osc) oclk <= 1'b1;
      else ext <= 1'b1;
      tick(8);
      oclk <= 1'b0;
      ext  <= 1'b0;
      tick(8);
    end
    wb(C, 1'b1, c & 8'hfe);
    wb(L, 1'b0, 8'h00);
    chk("edge count", q, 8'h05);
    chk("osc enable", {7'h00, amp}, {7'h00, c[3]});
    wb(C, 1'b1, 8'h00);
  endtask

  task automatic t_pins();
    dir  <= 2'b01;
    pout <= 2'b10;
    ext  <= 1'b1;
    tick(4);
    chk("idle oe_n", {6'h00, pins.oe_n}, 8'h01);
    chk("idle port read", {6'h00, pins.port_rd}, 8'h01);
    chk("port out", {6'h00, pins.out}, 8'h02);
    wb(C, 1'b1, 8'h01);
    tick(2);
    chk("run oe_n", {6'h00, pins.oe_n}, 8'h03);
    chk("run port read", {6'h00, pins.port_rd}, 8'h00);
    wb(C, 1'b1, 8'h00);
    ext <= 1'b0;
  endtask

  task automatic t_sys();
    sys <= 1'b1;
    tick(1);
    wb(C, 1'b0, 8'h00);
    chk("clock status set", q, 8'h40);
    sys <= 1'b0;
    wb(C, 1'b1, 8'h40);
    // write without byte lane 0 is ignored
    sel <= 4'h0;
    wb(C, 1'b1, 8'h01);
    sel <= 4'h1;
    wb(C, 1'b0, 8'h00);
    chk("clock status clear", q, 8'h00);
  endtask

  task automatic t_event();
    wb(H, 1'b1, 8'h12);
    wb(L, 1'b1, 8'h34);
    wb(C, 1'b1, 8'h01);
    sev <= 1'b1;
    tick(1);
    sev <= 1'b0;
    wb(C, 1'b1, 8'h00);
    wb(H, 1'b0, 8'h00);
    chk("event cleared high", q, 8'h00);
    wb(S, 1'b0, 8'h00);
    chk("event no flag", q, 8'h00);
    // event high exactly at the edge that takes a low-byte write
    fork
      wb(L, 1'b1, 8'h5a);
      begin
        sev <= 1'b1;
        @(posedge clk_i);
        sev <= 1'b0;
      end
    join
    wb(L, 1'b0, 8'h00);
    chk("write beats event", q, 8'h5a);
  endtask

  // free-running clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // reset, then each scenario in turn
  initial begin
    {cyc, stb, we, ext, oin, oclk, sys, sev} = 8'h00;
    {adr, dat, sel, dir, pout} = '0;
    sel = 4'h1;
    n_mismatch = 0;
    n_tests = 0;
    rst_i = 1'b1;
    tick(10);
    rst_i <= 1'b0;
    tick(1);
    t_reset();
    t_prescale();
    t_wide();
    t_ovf(1'b0);
    t_ovf(1'b1);
    t_ext(8'h03, 1'b0);
    t_ext(8'h07, 1'b0);
    t_ext(8'h0b, 1'b1);
    t_pins();
    t_sys();
    t_event();
    finish_test();
  end
endmodule // timer_counter_tb
`default_nettype wire
